// File: hdl/lpses_params.svh
// Constants for the doze and calibration-store sequencer.
// Included by both ends, the link checks and the bench; definitions only.
`ifndef LPSES_PARAMS_SVH
`define LPSES_PARAMS_SVH
// Command codes (8 bit) on the command link.
`define LPSES_CMD_NOP 8'h25
`define LPSES_CMD_PANEL_BLANK 8'hAE
`define LPSES_CMD_PANEL_SHOW 8'hAF
`define LPSES_CMD_DRIVE_SUPPLY 8'h20
`define LPSES_CMD_OSC_STOP 8'hD2
`define LPSES_CMD_OSC_RUN 8'hD1
`define LPSES_CMD_DOZE_ENTER 8'h95
`define LPSES_CMD_DOZE_EXIT 8'h94
`define LPSES_CMD_CONTRAST 8'h81
`define LPSES_CMD_TIMING_SETUP 8'hCA
`define LPSES_CMD_FRAME_WRITE 8'h5C
`define LPSES_CMD_NVM_ENTER 8'hCD
`define LPSES_CMD_NVM_EXIT 8'hCC
`define LPSES_CMD_NVM_STORE 8'hFC
`define LPSES_CMD_NVM_LOAD 8'hFD
`define LPSES_CMD_NVM_SEL_A 8'h7C
`define LPSES_CMD_NVM_SEL_B 8'h7D
`define LPSES_CMD_STATUS_FETCH 8'hFE
// Status byte bit positions.
`define LPSES_ST_BUSY 2
`define LPSES_ST_DISP 3
`define LPSES_ST_OSC 4
`define LPSES_ST_DOZE 5
`define LPSES_ST_TEST 6
// Parameter bit of the drive supply command selecting the first drive voltage source.
`define LPSES_VREF_SEL_BIT 4
// Oscillator division ratios and processing periods.
`define LPSES_ENTER_PERIODS 5
`define LPSES_STORE_PERIODS 10
`define LPSES_LOAD_PERIODS 10
`define LPSES_DIV_FAST 4
`define LPSES_DIV_SLOW 320
// Timing setup: division select 0 means divide by 2, line count field 32 gives 132 lines.
`define LPSES_TS_DIV2 2'h0
`define LPSES_TS_LINES 6'h20
// Drive supply settle time, ms, and clock rate.
`define LPSES_SETTLE_MS 100
`define LPSES_CLK_HZ 40000000
`define LPSES_SETTLE_CYC ((`LPSES_SETTLE_MS * (`LPSES_CLK_HZ / 1000)))
// Host register offsets (byte addresses).
`define LPSES_REG_CMD 4'h0
`define LPSES_REG_STATUS 4'h4
`define LPSES_REG_IRQ 4'h8
`define LPSES_REG_MASK 4'hC
// Host sequence codes written to the command register.
`define LPSES_SEQ_OFF 3'h1
`define LPSES_SEQ_DOZE 3'h2
`define LPSES_SEQ_WAKE 3'h3
`define LPSES_SEQ_STORE 3'h4
`define LPSES_SEQ_LOAD 3'h5
`define LPSES_SEQ_READBACK 3'h6
`define LPSES_SEQ_HWOFF 3'h7
`endif

// File: hdl/lpses_pkg.sv
// Types used by the device end of the sequencer link.
// Assumes lpses_params.svh on the include path.
package lpses_pkg;
   typedef enum logic [1:0] {
      LPSES_NVM_IDLE = 2'h0,
      LPSES_NVM_ENTER = 2'h1,
      LPSES_NVM_STORE = 2'h3,
      LPSES_NVM_LOAD = 2'h2
   } lpses_nvm_t;
endpackage

// File: hdl/lpses_if.sv
// Command link between host end and device end.
// Byte command/parameter strobe plus a status byte and hardware reset.
`timescale 1ns/100ps
interface lpses_if;
   logic cmd_valid;
   logic cmd_is_data;
   logic [7:0] cmd_byte;
   logic cmd_ready;
   logic [7:0] status_byte;
   logic hw_reset_n;
   modport device (input cmd_valid, input cmd_is_data, input cmd_byte, input hw_reset_n,
      output cmd_ready, output status_byte);
   modport host (output cmd_valid, output cmd_is_data, output cmd_byte, output hw_reset_n,
      input cmd_ready, input status_byte);
endinterface

// File: hdl/lpses_device.sv
// Device end: interprets commands, holds display/power/oscillator state and
// sequences calibration store accesses. Assumes the host keeps the power orders.
`timescale 1ns/100ps
`include "lpses_params.svh"
// Behaviour
// - Host powers down: blank, supply off, osc off, doze
// - Blank command blanks panel, outputs at mid level
// - Osc stop halts all internally clocked logic
// - Host holds reset low before removing supply
// - Doze keeps settings and memory, accepts commands
// - Host avoids frame memory writes while dozing
// - Wake: doze exit, osc run, wait, show
// - Show command drives panel from memory
// - Host periodically reissues full refresh sequence (lpses_host issues no periodic refresh)
// - No-operation leaves factory test state
// - Host changes timing setup only when blanked
// - Store access needs osc running, div2, 132 lines
// - Store: set contrast, enter, store, exit
// - Load: enter, load, exit updates contrast
// - Select command returns contrast on status read
// - Host waits the documented processing periods
// - Busy flag shows ongoing store access
// - Supply bit selects store or divider reference
module lpses_device #(
   parameter int OSC_DIV = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Command link
   lpses_if.device link,
   // Calibration store side
   output logic nvm_write,
   output logic nvm_read,
   output logic [7:0] nvm_wdata,
   input wire logic [7:0] nvm_rdata,
   // Panel drive
   output logic panel_on,
   output logic mid_drive_level,
   output logic supply_on,
   output logic osc_on,
   output logic doze,
   output logic vref_source_sel,
   output logic [7:0] contrast
);
   typedef struct packed {
      logic disp;
      logic supply;
      logic osc;
      logic doze;
      logic test;
      logic vsel;
      logic [7:0] contrast;
      logic [1:0] ts_div;
      logic [5:0] ts_lines;
      logic [7:0] last_cmd;
      logic [1:0] pcount;
      logic nvm_wr_mode;
      logic nvm_loaded;
      logic [7:0] nvm_buf;
      lpses_pkg::lpses_nvm_t nvm;
      logic [12:0] busy_cnt;
      logic [8:0] osc_cnt;
      logic [7:0] status;
      logic nwr;
      logic nrd;
   } lpses_dev_t;

   lpses_dev_t r;
   lpses_dev_t next_r;
   logic tick;

   // Periods of the divided oscillator; the internal oscillator is the clock divided by OSC_DIV.
   function automatic logic [12:0] periods(input logic [3:0] n, input logic [8:0] div);
      periods = 13'(n * div * OSC_DIV);
   endfunction

   assign tick = r.osc;

   always_comb begin
      next_r = r;
      next_r.nwr = 1'b0;
      next_r.nrd = 1'b0;
      if (tick && r.busy_cnt != 13'h0) begin
         next_r.busy_cnt = r.busy_cnt - 13'h1;
      end
      if (link.cmd_valid && !link.cmd_is_data) begin
         next_r.last_cmd = link.cmd_byte;
         next_r.pcount = 2'h0;
         case (link.cmd_byte)
            `LPSES_CMD_PANEL_BLANK: next_r.disp = 1'b0;
            `LPSES_CMD_PANEL_SHOW: next_r.disp = 1'b1;
            `LPSES_CMD_OSC_STOP: next_r.osc = 1'b0;
            `LPSES_CMD_OSC_RUN: next_r.osc = 1'b1;
            `LPSES_CMD_DOZE_ENTER: begin
               // Only display, supply and oscillator are dropped; all else is kept.
               next_r.doze = 1'b1;
               next_r.disp = 1'b0;
               next_r.supply = 1'b0;
               next_r.osc = 1'b0;
            end
            `LPSES_CMD_DOZE_EXIT: next_r.doze = 1'b0;
            `LPSES_CMD_NOP: next_r.test = 1'b0;
            `LPSES_CMD_NVM_ENTER: begin
               next_r.nvm = lpses_pkg::LPSES_NVM_ENTER;
               next_r.busy_cnt = periods(4'(`LPSES_ENTER_PERIODS), 9'(`LPSES_DIV_FAST));
            end
            `LPSES_CMD_NVM_STORE: begin
               if (r.nvm != lpses_pkg::LPSES_NVM_IDLE) begin
                  next_r.nvm = lpses_pkg::LPSES_NVM_STORE;
                  next_r.nwr = 1'b1;
                  next_r.busy_cnt = periods(4'(`LPSES_STORE_PERIODS), 9'(`LPSES_DIV_SLOW));
               end
            end
            `LPSES_CMD_NVM_LOAD: begin
               if (r.nvm != lpses_pkg::LPSES_NVM_IDLE) begin
                  next_r.nvm = lpses_pkg::LPSES_NVM_LOAD;
                  next_r.nrd = 1'b1;
                  next_r.busy_cnt = periods(4'(`LPSES_LOAD_PERIODS), 9'(`LPSES_DIV_FAST));
               end
            end
            `LPSES_CMD_NVM_EXIT: begin
               if (r.nvm == lpses_pkg::LPSES_NVM_LOAD && r.nvm_loaded) begin
                  next_r.contrast = r.nvm_buf;
               end
               next_r.nvm = lpses_pkg::LPSES_NVM_IDLE;
               next_r.nvm_loaded = 1'b0;
            end
            `LPSES_CMD_NVM_SEL_A, `LPSES_CMD_NVM_SEL_B: next_r.status = r.contrast;
            `LPSES_CMD_STATUS_FETCH: next_r.last_cmd = r.last_cmd;
            default: ;
         endcase
      end else if (link.cmd_valid) begin
         next_r.pcount = r.pcount + 2'h1;
         case (r.last_cmd)
            `LPSES_CMD_DRIVE_SUPPLY: begin
               next_r.supply = link.cmd_byte[3:0] != 4'h0;
               next_r.vsel = link.cmd_byte[`LPSES_VREF_SEL_BIT];
            end
            `LPSES_CMD_CONTRAST: next_r.contrast = link.cmd_byte;
            `LPSES_CMD_NVM_ENTER: next_r.nvm_wr_mode = link.cmd_byte[0];
            `LPSES_CMD_TIMING_SETUP: begin
               if (r.pcount == 2'h0) begin
                  next_r.ts_div = link.cmd_byte[1:0];
               end
               if (r.pcount == 2'h1) begin
                  next_r.ts_lines = link.cmd_byte[5:0];
               end
            end
            default: ;
         endcase
      end
      // Read data is latched once the load access has had time to settle.
      if (r.nvm == lpses_pkg::LPSES_NVM_LOAD && r.busy_cnt == 13'h1 && tick) begin
         next_r.nvm_buf = nvm_rdata;
         next_r.nvm_loaded = 1'b1;
      end
      // Status is live so that busy can be polled; after a select it carries the contrast instead.
      if (next_r.last_cmd != `LPSES_CMD_NVM_SEL_A && next_r.last_cmd != `LPSES_CMD_NVM_SEL_B) begin
         next_r.status = 8'h00;
         next_r.status[`LPSES_ST_BUSY] = (next_r.busy_cnt != 13'h0);
         next_r.status[`LPSES_ST_DISP] = next_r.disp;
         next_r.status[`LPSES_ST_OSC] = next_r.osc;
         next_r.status[`LPSES_ST_DOZE] = next_r.doze;
         next_r.status[`LPSES_ST_TEST] = next_r.test;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst || !link.hw_reset_n) begin
         r <= '0;
         r.test <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign link.cmd_ready = 1'b1;
   assign link.status_byte = r.status;
   assign nvm_write = r.nwr;
   assign nvm_read = r.nrd;
   assign nvm_wdata = r.contrast;
   // The panel is driven from the display and oscillator flags only; the drive supply flag does not gate it.
   assign panel_on = r.disp && r.osc;
   assign mid_drive_level = !r.disp;
   assign supply_on = r.supply;
   assign osc_on = r.osc;
   assign doze = r.doze;
   assign vref_source_sel = r.vsel;
   assign contrast = r.contrast;
endmodule // lpses_device

// File: hdl/lpses_host.sv
// Host end: Avalon-MM slave with a sequence command register; plays out the
// documented power, doze and calibration orders on the command link.
//
// Implementation choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/100ps
`include "lpses_params.svh"
module lpses_host #(
   parameter int SETTLE_CYC = `LPSES_SETTLE_CYC,
   parameter int POLL_GAP = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq,
   // Command link
   lpses_if.host link
);
   typedef enum logic [2:0] {
      H_IDLE = 3'h0, H_SEND = 3'h1, H_POLL = 3'h3, H_WAIT = 3'h2, H_DONE = 3'h6
   } lpses_hst_t;
   typedef struct packed {
      lpses_hst_t st;
      logic [2:0] seq;
      logic [3:0] step;
      logic [7:0] param;
      logic [31:0] cnt;
      logic [7:0] result;
      logic [1:0] irq_st;
      logic [1:0] mask;
      logic rst_n;
      logic [31:0] rdata;
      logic rvalid;
   } lpses_host_st_t;
   lpses_host_st_t r;
   lpses_host_st_t next_r;
   logic [8:0] word;
   logic last;

   // Step table: bit 8 marks a data byte, bits 7:0 the byte; zero ends the sequence.
   function automatic logic [8:0] step_word(input logic [2:0] seq, input logic [3:0] step,
         input logic [7:0] p);
      logic is_store;
      is_store = (seq == `LPSES_SEQ_STORE);
      step_word = 9'h000;
      case (seq)
         `LPSES_SEQ_OFF, `LPSES_SEQ_DOZE: case (step)
            4'h0: step_word = {1'b0, `LPSES_CMD_PANEL_BLANK};
            4'h1: step_word = {1'b0, `LPSES_CMD_DRIVE_SUPPLY};
            4'h2: step_word = {1'b1, 8'h00};
            4'h3: step_word = {1'b0, `LPSES_CMD_OSC_STOP};
            4'h4: step_word = {1'b0, `LPSES_CMD_DOZE_ENTER};
            default: ;
         endcase
         `LPSES_SEQ_WAKE: case (step)
            4'h0: step_word = {1'b0, `LPSES_CMD_DOZE_EXIT};
            4'h1: step_word = {1'b0, `LPSES_CMD_OSC_RUN};
            4'h2: step_word = {1'b0, `LPSES_CMD_PANEL_SHOW};
            default: ;
         endcase
         // Blanking first keeps the timing setup off a lit panel.
         `LPSES_SEQ_STORE, `LPSES_SEQ_LOAD: case (step)
            4'h0: step_word = {1'b0, `LPSES_CMD_PANEL_BLANK};
            4'h1: step_word = {1'b0, `LPSES_CMD_OSC_RUN};
            4'h2: step_word = {1'b0, `LPSES_CMD_TIMING_SETUP};
            4'h3: step_word = {1'b1, 6'h0, `LPSES_TS_DIV2};
            4'h4: step_word = {1'b1, 2'h0, `LPSES_TS_LINES};
            4'h5: step_word = is_store ? {1'b0, `LPSES_CMD_CONTRAST} : {1'b0, `LPSES_CMD_NOP};
            4'h6: step_word = is_store ? {1'b1, p} : {1'b0, `LPSES_CMD_NVM_ENTER};
            4'h7: step_word = is_store ? {1'b0, `LPSES_CMD_NVM_ENTER} : {1'b1, 8'h00};
            4'h8: step_word = is_store ? {1'b1, 8'h01} : {1'b0, `LPSES_CMD_NVM_LOAD};
            4'h9: step_word = is_store ? {1'b0, `LPSES_CMD_NVM_STORE} : {1'b0, `LPSES_CMD_NVM_EXIT};
            4'hA: step_word = is_store ? {1'b0, `LPSES_CMD_NVM_EXIT} : 9'h000;
            default: ;
         endcase
         `LPSES_SEQ_READBACK: case (step)
            4'h0: step_word = {1'b0, `LPSES_CMD_NVM_SEL_A};
            4'h1: step_word = {1'b0, `LPSES_CMD_STATUS_FETCH};
            default: ;
         endcase
         default: ;
      endcase
   endfunction

   assign word = step_word(r.seq, r.step, r.param);
   assign last = (step_word(r.seq, r.step + 4'h1, r.param) == 9'h000);

   always_comb begin
      next_r = r;
      next_r.rvalid = 1'b0;
      if (avs_write && r.st == H_IDLE && avs_address == `LPSES_REG_CMD) begin
         next_r.seq = avs_writedata[2:0];
         next_r.param = avs_writedata[15:8];
         next_r.step = 4'h0;
         if (avs_writedata[2:0] == `LPSES_SEQ_HWOFF) begin
            next_r.rst_n = 1'b0;
            next_r.st = H_DONE;
         end else begin
            next_r.rst_n = 1'b1;
            next_r.st = H_SEND;
         end
      end else if (avs_write && avs_address == `LPSES_REG_MASK) begin
         next_r.mask = avs_writedata[1:0];
      end
      if (avs_read && !r.rvalid) begin
         case (avs_address)
            `LPSES_REG_CMD: next_r.rdata = {29'h0, r.seq};
            `LPSES_REG_STATUS: next_r.rdata = {23'h0, r.st != H_IDLE, r.result};
            `LPSES_REG_IRQ: begin
               next_r.rdata = {30'h0, r.irq_st};
               next_r.irq_st = 2'h0;
            end
            `LPSES_REG_MASK: next_r.rdata = {30'h0, r.mask};
            default: next_r.rdata = 32'h0;
         endcase
         next_r.rvalid = 1'b1;
      end
      case (r.st)
         H_SEND: begin
            if (link.cmd_ready) begin
               next_r.step = r.step + 4'h1;
               next_r.cnt = 32'h0;
               if (r.seq == `LPSES_SEQ_WAKE && r.step == 4'h1) begin
                  next_r.st = H_WAIT;
               end else if ((r.seq == `LPSES_SEQ_STORE && (r.step == 4'h8 || r.step == 4'h9)) ||
                     (r.seq == `LPSES_SEQ_LOAD && (r.step == 4'h7 || r.step == 4'h8))) begin
                  // Each store access must finish before the next command.
                  next_r.st = H_POLL;
               end else if (last) begin
                  next_r.st = (r.seq == `LPSES_SEQ_READBACK) ? H_WAIT : H_DONE;
               end
            end
         end
         H_POLL: begin
            // Busy polling replaces fixed timers.
            next_r.cnt = r.cnt + 32'h1;
            if (r.cnt >= 32'(POLL_GAP) && !link.status_byte[`LPSES_ST_BUSY]) begin
               next_r.st = H_SEND;
            end
         end
         H_WAIT: begin
            next_r.cnt = r.cnt + 32'h1;
            if (r.seq == `LPSES_SEQ_READBACK) begin
               next_r.result = link.status_byte;
               next_r.st = H_DONE;
            end else if (r.cnt >= 32'(SETTLE_CYC)) begin
               next_r.st = H_SEND;
            end
         end
         H_DONE: begin
            next_r.irq_st = r.irq_st | 2'h1;
            next_r.st = H_IDLE;
         end
         default: ;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         r <= '0;
         r.rst_n <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign link.cmd_valid = (r.st == H_SEND);
   assign link.cmd_is_data = (r.st == H_SEND) ? word[8] : 1'b0;
   assign link.cmd_byte = (r.st == H_SEND) ? word[7:0] : 8'h00;
   assign link.hw_reset_n = r.rst_n;
   assign avs_waitrequest = (avs_read && !r.rvalid);
   assign avs_readdata = r.rdata;
   assign irq = |(r.irq_st & r.mask);
endmodule // lpses_host

// File: dv/lpses_link_properties.sv
// Concurrent checks on the command link between the host end and the device end.
// Assumes one clock domain and that it sees only the link signals, clock and reset.
`timescale 1ns/100ps
`include "lpses_params.svh"
module lpses_link_properties #(
   parameter int SETTLE_CYC = 50
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Command link
   input wire logic cmd_valid,
   input wire logic cmd_is_data,
   input wire logic [7:0] cmd_byte,
   input wire logic cmd_ready,
   input wire logic [7:0] status_byte,
   input wire logic hw_reset_n
);
   localparam int BUSY_MAX = 8000;
   logic cmd_go;
   logic nvm_mode;
   logic sel_mode;
   int settle_cnt;
   int busy_cnt;
   assign cmd_go = cmd_valid && !cmd_is_data;
   // Mode and counts are rebuilt from the link alone, so they do not depend on the internal state of either end.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         nvm_mode <= 1'b0;
         sel_mode <= 1'b0;
         settle_cnt <= 0;
         busy_cnt <= 0;
      end else begin
         if (cmd_go && cmd_byte == `LPSES_CMD_NVM_ENTER) nvm_mode <= 1'b1;
         if (cmd_go && cmd_byte == `LPSES_CMD_NVM_EXIT) nvm_mode <= 1'b0;
         if (cmd_go && cmd_byte == `LPSES_CMD_OSC_RUN) settle_cnt <= 0;
         else if (settle_cnt <= SETTLE_CYC) settle_cnt <= settle_cnt + 1;
         // After a select the status carries the contrast, so its busy bit means nothing then.
         if (cmd_go && (cmd_byte == `LPSES_CMD_NVM_SEL_A || cmd_byte == `LPSES_CMD_NVM_SEL_B)) sel_mode <= 1'b1;
         else if (cmd_go && cmd_byte != `LPSES_CMD_STATUS_FETCH) sel_mode <= 1'b0;
         busy_cnt <= (status_byte[`LPSES_ST_BUSY] && !sel_mode) ? busy_cnt + 1 : 0;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   a_blank_clears_disp: assert property (cmd_go && cmd_byte == `LPSES_CMD_PANEL_BLANK |-> ##[1:3] !status_byte[`LPSES_ST_DISP])
      else $error("display flag still set after blank command");
   a_show_sets_disp: assert property (cmd_go && cmd_byte == `LPSES_CMD_PANEL_SHOW |-> ##[1:3] status_byte[`LPSES_ST_DISP])
      else $error("display flag not set after show command");
   a_osc_stop_halts: assert property (cmd_go && cmd_byte == `LPSES_CMD_OSC_STOP |-> ##[1:3] !status_byte[`LPSES_ST_OSC])
      else $error("oscillator flag still set after stop command");
   a_doze_enter_flag: assert property (cmd_go && cmd_byte == `LPSES_CMD_DOZE_ENTER |-> ##[1:3] status_byte[`LPSES_ST_DOZE])
      else $error("doze flag not set after doze command");
   a_doze_accepts_cmd: assert property (status_byte[`LPSES_ST_DOZE] |-> cmd_ready)
      else $error("commands refused while dozing");
   a_nop_ends_test: assert property (cmd_go && cmd_byte == `LPSES_CMD_NOP |-> ##[1:3] !status_byte[`LPSES_ST_TEST])
      else $error("test state kept after no-operation");
   a_show_after_settle: assert property (cmd_go && cmd_byte == `LPSES_CMD_PANEL_SHOW |-> settle_cnt >= SETTLE_CYC)
      else $error("show command sent before supply settle time");
   a_nvm_op_in_mode: assert property (cmd_go && (cmd_byte == `LPSES_CMD_NVM_STORE || cmd_byte == `LPSES_CMD_NVM_LOAD)
      |-> nvm_mode)
      else $error("store or load outside store control mode");
   a_no_cmd_while_busy: assert property (cmd_go && !sel_mode && cmd_byte != `LPSES_CMD_STATUS_FETCH
      |-> !status_byte[`LPSES_ST_BUSY])
      else $error("command sent while store access busy");
   a_busy_bounded: assert property (busy_cnt <= BUSY_MAX)
      else $error("busy flag stuck");
   a_timing_blanked: assert property (cmd_go && cmd_byte == `LPSES_CMD_TIMING_SETUP |-> !status_byte[`LPSES_ST_DISP])
      else $error("timing setup sent while display on");
   a_hw_reset_off: assert property ($fell(hw_reset_n) |-> ##[1:3] !status_byte[`LPSES_ST_DISP] && !status_byte[`LPSES_ST_OSC])
      else $error("device not off after hardware reset");
   c_store: cover property (cmd_go && cmd_byte == `LPSES_CMD_NVM_STORE);
   c_load: cover property (cmd_go && cmd_byte == `LPSES_CMD_NVM_LOAD);
   c_show: cover property (cmd_go && cmd_byte == `LPSES_CMD_PANEL_SHOW);
   c_hw_reset: cover property ($fell(hw_reset_n));
endmodule // lpses_link_properties

// File: dv/test_lpses.sv
// Self-checking bench: host and device ends joined by the link, driven over Avalon-MM.
// Assumes a 40 MHz clock and the supply settle count shortened to 50 cycles.
`timescale 1ns/100ps
`include "lpses_params.svh"
module test_lpses;
   logic clk;
   logic sys_rst;
   logic [3:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic irq;
   logic nvm_write;
   logic nvm_read;
   logic [7:0] nvm_wdata;
   logic [7:0] nvm_rdata;
   logic panel_on;
   logic mid_drive_level;
   logic supply_on;
   logic osc_on;
   logic doze;
   logic vref_source_sel;
   logic [7:0] contrast;
   int err_count = 0;
   int n_compared = 0;
   int n_store = 0;
   int n_load = 0;
   int n_hwrst = 0;
   int seed;
   logic [31:0] rd;
   logic [7:0] c;
   logic [7:0] r;
   lpses_if lpses_if_i ();
   lpses_host #(.SETTLE_CYC(50), .POLL_GAP(4)) lpses_host_i (.clk(clk), .sys_rst(sys_rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .link(lpses_if_i.host));
   lpses_device lpses_device_i (.clk(clk), .sys_rst(sys_rst), .link(lpses_if_i.device), .nvm_write(nvm_write),
      .nvm_read(nvm_read), .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata), .panel_on(panel_on),
      .mid_drive_level(mid_drive_level), .supply_on(supply_on), .osc_on(osc_on), .doze(doze),
      .vref_source_sel(vref_source_sel), .contrast(contrast));
   lpses_link_properties #(.SETTLE_CYC(50)) lpses_link_properties_i (.clk(clk), .sys_rst(sys_rst),
      .cmd_valid(lpses_if_i.cmd_valid), .cmd_is_data(lpses_if_i.cmd_is_data), .cmd_byte(lpses_if_i.cmd_byte),
      .cmd_ready(lpses_if_i.cmd_ready), .status_byte(lpses_if_i.status_byte), .hw_reset_n(lpses_if_i.hw_reset_n));
   function automatic logic [31:0] exp_word(input logic [2:0] s, input logic [7:0] v);
      return {16'h0000, v, 5'h00, s};
   endfunction
   // Panel shown implies mid level released, so both pins come from one flag.
   function automatic logic [3:0] exp_pins(input logic p, input logic o, input logic d);
      return {p, !p, o, d};
   endfunction
   task automatic test_done();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic fail(input string what);
      err_count++;
      $display("mismatch at %0t: %s", $time, what);
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) fail($sformatf("%s got %h expected %h", what, got, exp));
   endtask
   // Entered just after a rising edge; values are read at the edge before the design's updates land.
   task automatic bus(input logic [3:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 100);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n >= 100) fail("bus answer missing");
      @(posedge clk);
   endtask
   task automatic run(input logic [2:0] s, input logic [7:0] v, output logic [31:0] st);
      int k;
      k = 0;
      bus(`LPSES_REG_CMD, 1'b1, exp_word(s, v), st);
      do begin
         bus(`LPSES_REG_STATUS, 1'b0, 32'h0, st);
         k++;
      end while (st[8] !== 1'b0 && k < 5000);
      if (k >= 5000) fail("sequence never finished");
   endtask
   always @(posedge clk) begin
      if (nvm_write === 1'b1) n_store++;
      if (nvm_read === 1'b1) n_load++;
      if (lpses_if_i.hw_reset_n === 1'b0) n_hwrst++;
   end
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      repeat (90000) @(posedge clk);
      fail("watchdog expired");
      test_done();
   end
   initial begin
      seed = 83086;
      sys_rst = 1'b1;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      nvm_rdata = 8'h00;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      bus(`LPSES_REG_IRQ, 1'b0, 32'h0, rd);
      check(rd, 32'h0, "irq status after reset");
      // Raise the done event while masked, then unmask and clear it by reading.
      bus(`LPSES_REG_MASK, 1'b1, 32'h0, rd);
      run(`LPSES_SEQ_WAKE, 8'h00, rd);
      check({3'h0, exp_pins(1'b1, 1'b1, 1'b0)}, {3'h0, panel_on, mid_drive_level, osc_on, doze}, "wake pins");
      check({31'h0, irq}, 32'h0, "masked irq");
      bus(`LPSES_REG_MASK, 1'b1, 32'h1, rd);
      check({31'h0, irq}, 32'h1, "unmasked irq");
      bus(`LPSES_REG_IRQ, 1'b0, 32'h0, rd);
      check({31'h0, rd[0]}, 32'h1, "irq done bit");
      check({31'h0, irq}, 32'h0, "irq after clear");
      // Store, load and read back; first pass uses the extreme byte values.
      for (int i = 0; i < 3; i++) begin
         c = (i == 0) ? 8'hFF : 8'($random(seed));
         r = (i == 0) ? 8'h00 : 8'($random(seed));
         run(`LPSES_SEQ_STORE, c, rd);
         check({24'h0, contrast}, {24'h0, c}, "stored contrast");
         check({24'h0, nvm_wdata}, {24'h0, c}, "store data");
         check(n_store, i + 1, "store pulses");
         nvm_rdata <= r;
         run(`LPSES_SEQ_LOAD, 8'h00, rd);
         check({24'h0, contrast}, {24'h0, r}, "loaded contrast");
         check(n_load, i + 1, "load pulses");
         run(`LPSES_SEQ_READBACK, 8'h00, rd);
         check({24'h0, rd[7:0]}, {24'h0, r}, "readback result");
      end
      // A command written while busy is ignored.
      bus(`LPSES_REG_CMD, 1'b1, exp_word(`LPSES_SEQ_STORE, 8'h5A), rd);
      run(`LPSES_SEQ_LOAD, 8'h00, rd);
      check(n_load, 3, "load refused while busy");
      check(n_store, 4, "store while busy");
      c = contrast;
      run(`LPSES_SEQ_DOZE, 8'h00, rd);
      check({3'h0, exp_pins(1'b0, 1'b0, 1'b1)}, {3'h0, panel_on, mid_drive_level, osc_on, doze}, "doze pins");
      check({31'h0, supply_on}, 32'h0, "supply in doze");
      check({24'h0, contrast}, {24'h0, c}, "contrast kept in doze");
      run(`LPSES_SEQ_WAKE, 8'h00, rd);
      check({3'h0, exp_pins(1'b1, 1'b1, 1'b0)}, {3'h0, panel_on, mid_drive_level, osc_on, doze}, "rewake pins");
      check({24'h0, contrast}, {24'h0, c}, "contrast kept after wake");
      run(`LPSES_SEQ_OFF, 8'h00, rd);
      check({3'h0, exp_pins(1'b0, 1'b0, 1'b1)}, {3'h0, panel_on, mid_drive_level, osc_on, doze}, "off pins");
      check({31'h0, supply_on}, 32'h0, "supply off");
      run(`LPSES_SEQ_WAKE, 8'h00, rd);
      run(`LPSES_SEQ_HWOFF, 8'h00, rd);
      check({31'h0, n_hwrst > 0}, 32'h1, "hardware reset driven");
      check({30'h0, panel_on, osc_on}, 32'h0, "off after hardware reset");
      bus(4'h2, 1'b0, 32'h0, rd);
      check(rd, 32'h0, "unmapped read");
      test_done();
   end
endmodule // test_lpses
